// *** hdl/i2cmc_pkg.sv ***
// Constants and types for the two-wire bus master controller.
// Contract
// [R1] Master only; never answers as target.
// [R2] Multi-master: wait bus free, arbitrate.
// [R3] Three rates: 100 kHz, 400 kHz, 1 MHz.
// [R4] Lowest supply level forces standard rate.
// [R5] Higher supply levels allow fast, fast-plus.
// [R6] Wait while target holds clock low.
// [R7] Start, stop, bytes, acknowledge per protocol.
// [R8] Arbitration loss: release lines, flag it.
package i2cmc_pkg;
    // Link clock rate and the three bus rates.
    localparam int unsigned LINK_HZ  = 6250000;
    localparam int unsigned STD_HZ   = 100000;
    localparam int unsigned FAST_HZ  = 400000;
    localparam int unsigned FPLUS_HZ = 1000000;
    // Rate select codes; any other code means standard.
    localparam logic [1:0] RATE_STD   = 2'h0;
    localparam logic [1:0] RATE_FAST  = 2'h1;
    localparam logic [1:0] RATE_FPLUS = 2'h2;
    // Link clock cycles per quarter of a bus bit, rounded up so the bus never runs above its rate.
    localparam logic [4:0] QTR_STD   = 5'((LINK_HZ + 4 * STD_HZ - 1) / (4 * STD_HZ));
    localparam logic [4:0] QTR_FAST  = 5'((LINK_HZ + 4 * FAST_HZ - 1) / (4 * FAST_HZ));
    localparam logic [4:0] QTR_FPLUS = 5'((LINK_HZ + 4 * FPLUS_HZ - 1) / (4 * FPLUS_HZ));
    // Bit index of the acknowledge slot within a byte.
    localparam logic [3:0] ACK_BIT = 4'h8;
    // Quarter phases within one bit.
    localparam logic [1:0] Q0 = 2'h0;
    localparam logic [1:0] Q1 = 2'h1;
    localparam logic [1:0] Q2 = 2'h2;
    localparam logic [1:0] Q3 = 2'h3;
    // Link engine states.
    typedef enum logic [2:0] {
        S_IDLE,
        S_WAIT,
        S_START,
        S_BIT,
        S_STOP,
        S_DONE
    } i2cmc_state_t;
endpackage

// *** hdl/i2cmc_top.sv ***
// Two-wire bus master controller with a command port and a link-clock bit engine.
`timescale 1ns/1ps
`default_nettype none
module i2cmc_top (
    input  wire logic       clk,                      // Core clock.
    input  wire logic       resetn,                   // Asynchronous reset, active low.
    input  wire logic       link_clk,                 // Clock of the bit engine.
    input  wire logic       cmd_valid,                // Command offered.
    output logic            cmd_ready,                // Command can be taken.
    input  wire logic       cmd_start,                // Issue start before the byte.
    input  wire logic       cmd_stop,                 // Issue stop after the byte.
    input  wire logic       cmd_read,                 // Read a byte instead of writing.
    input  wire logic       cmd_ack,                  // On read, acknowledge the byte.
    input  wire logic [7:0] cmd_wdata,                // Byte to write.
    input  wire logic [1:0] cmd_rate,                 // Bus rate select.
    input  wire logic       serial_bus_io_supply_low, // Bus supply at lowest level.
    output logic            rsp_valid,                // Command finished, one pulse.
    output logic [7:0]      rsp_rdata,                // Byte read.
    output logic            rsp_nack,                 // Acknowledge slot seen high.
    output logic            rsp_lost,                 // Command ended by lost arbitration.
    output logic            arb_lost,                 // Sticky arbitration loss flag.
    input  wire logic       arb_clear,                // Clears the loss flag.
    output logic            bus_busy,                 // Bus held by some master.
    input  wire logic       scl_i,                    // Clock line level.
    output logic            scl_o,                    // Clock line drive value.
    output logic            scl_oe,                   // Clock line pulled low.
    input  wire logic       sda_i,                    // Data line level.
    output logic            sda_o,                    // Data line drive value.
    output logic            sda_oe                    // Data line pulled low.
);
    // Core-domain command holding and handshake state.
    logic       busy_r;
    logic       req_tgl_r;
    logic       c_start_r;
    logic       c_stop_r;
    logic       c_read_r;
    logic       c_ack_r;
    logic [7:0] c_wdata_r;
    logic [1:0] c_rate_r;
    logic       sup_s1_r;
    logic       sup_s2_r;
    logic       dn_s1_r;
    logic       dn_s2_r;
    logic       dn_s3_r;
    logic       bb_s1_r;
    logic       bb_s2_r;
    logic       rsp_valid_r;
    logic [7:0] rsp_rdata_r;
    logic       rsp_nack_r;
    logic       rsp_lost_r;
    logic       arb_lost_r;
    // Link-domain state.
    i2cmc_pkg::i2cmc_state_t st_r;
    logic       rq_s1_r;
    logic       rq_s2_r;
    logic       rq_s3_r;
    logic       scl_s1_r;
    logic       scl_s2_r;
    logic       sda_s1_r;
    logic       sda_s2_r;
    logic       sda_d_r;
    logic       lbusy_r;
    logic       own_r;
    logic [1:0] q_r;
    logic [4:0] div_r;
    logic [3:0] bit_r;
    logic [7:0] sh_r;
    logic       scl_oe_r;
    logic       sda_oe_r;
    logic       nack_r;
    logic       lost_r;
    logic       done_tgl_r;
    logic [7:0] rdata_r;

    // Command handshake decode.
    wire accept  = cmd_valid && !busy_r;
    wire done_ev = dn_s2_r ^ dn_s3_r;
    // Rate limited by the supply level before it is held.
    wire [1:0] rate_fast = (cmd_rate == i2cmc_pkg::RATE_FPLUS) ? i2cmc_pkg::RATE_FPLUS :
                           (cmd_rate == i2cmc_pkg::RATE_FAST) ? i2cmc_pkg::RATE_FAST :
                           i2cmc_pkg::RATE_STD;
    // [R4] Low supply forces standard.
    // [R5] Fast rates otherwise allowed.
    wire [1:0] rate_eff  = sup_s2_r ? i2cmc_pkg::RATE_STD : rate_fast;

    assign cmd_ready = !busy_r;
    assign rsp_valid = rsp_valid_r;
    assign rsp_rdata = rsp_rdata_r;
    assign rsp_nack  = rsp_nack_r;
    assign rsp_lost  = rsp_lost_r;
    assign arb_lost  = arb_lost_r;
    assign bus_busy  = bb_s2_r;

    // Synchronisers into the core domain.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sup_s1_r <= 1'b0;
            sup_s2_r <= 1'b0;
            dn_s1_r  <= 1'b0;
            dn_s2_r  <= 1'b0;
            dn_s3_r  <= 1'b0;
            bb_s1_r  <= 1'b0;
            bb_s2_r  <= 1'b0;
        end else begin
            sup_s1_r <= serial_bus_io_supply_low;
            sup_s2_r <= sup_s1_r;
            dn_s1_r  <= done_tgl_r;
            dn_s2_r  <= dn_s1_r;
            dn_s3_r  <= dn_s2_r;
            bb_s1_r  <= lbusy_r;
            bb_s2_r  <= bb_s1_r;
        end
    end

    // Command capture; fields stay stable until the engine reports back.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            busy_r    <= 1'b0;
            req_tgl_r <= 1'b0;
            c_start_r <= 1'b0;
            c_stop_r  <= 1'b0;
            c_read_r  <= 1'b0;
            c_ack_r   <= 1'b0;
            c_wdata_r <= 8'h00;
            c_rate_r  <= i2cmc_pkg::RATE_STD;
        end else if (accept) begin
            busy_r    <= 1'b1;
            req_tgl_r <= !req_tgl_r;
            c_start_r <= cmd_start;
            c_stop_r  <= cmd_stop;
            c_read_r  <= cmd_read;
            c_ack_r   <= cmd_ack;
            c_wdata_r <= cmd_wdata;
            c_rate_r  <= rate_eff;
        end else if (done_ev) begin
            busy_r <= 1'b0;
        end
    end

    // Response capture; the loss flag is set in preference to a clear.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rsp_valid_r <= 1'b0;
            rsp_rdata_r <= 8'h00;
            rsp_nack_r  <= 1'b0;
            rsp_lost_r  <= 1'b0;
            arb_lost_r  <= 1'b0;
        end else begin
            rsp_valid_r <= done_ev;
            if (done_ev) begin
                rsp_rdata_r <= rdata_r;
                rsp_nack_r  <= nack_r;
                rsp_lost_r  <= lost_r;
            end
            // [R8] Sticky loss flag.
            if (done_ev && lost_r) begin
                arb_lost_r <= 1'b1;
            end else if (arb_clear) begin
                arb_lost_r <= 1'b0;
            end
        end
    end

    // Link-domain decode: quarter length, stretch hold and bit values.
    // [R3] Quarter length per rate.
    wire [4:0] qtr = (c_rate_r == i2cmc_pkg::RATE_FPLUS) ? i2cmc_pkg::QTR_FPLUS :
                     (c_rate_r == i2cmc_pkg::RATE_FAST) ? i2cmc_pkg::QTR_FAST :
                     i2cmc_pkg::QTR_STD;
    wire req_ev     = rq_s2_r ^ rq_s3_r;
    wire active     = (st_r == i2cmc_pkg::S_START) || (st_r == i2cmc_pkg::S_BIT) ||
                      (st_r == i2cmc_pkg::S_STOP);
    // [R6] Hold while clock released but low.
    wire stretch    = !scl_oe_r && !scl_s2_r;
    wire tick       = active && (div_r == 5'h0) && !stretch;
    wire is_ack     = (bit_r == i2cmc_pkg::ACK_BIT);
    wire drive_low  = is_ack ? (c_read_r && c_ack_r) : (!c_read_r && !sh_r[7]);
    wire sending    = is_ack ? c_read_r : !c_read_r;
    wire need_start = c_start_r || !own_r;
    // [R2] Start and stop seen on the bus.
    wire start_det  = scl_s2_r && sda_d_r && !sda_s2_r;
    wire stop_det   = scl_s2_r && !sda_d_r && sda_s2_r;
    // [R2] Released high but line low means lost.
    wire lose_bit   = (st_r == i2cmc_pkg::S_BIT) && (q_r == i2cmc_pkg::Q2) && sending &&
                      !sda_oe_r && !sda_s2_r;
    wire lose_start = (st_r == i2cmc_pkg::S_START) && (q_r == i2cmc_pkg::Q2) && !sda_s2_r;
    wire lose       = tick && (lose_bit || lose_start);

    // Open-drain pins: only ever pulled low.
    assign scl_o  = 1'b0;
    assign sda_o  = 1'b0;
    assign scl_oe = scl_oe_r;
    assign sda_oe = sda_oe_r;

    // Pin and request synchronisers, bus-busy tracking.
    always_ff @(posedge link_clk or negedge resetn) begin
        if (!resetn) begin
            rq_s1_r  <= 1'b0;
            rq_s2_r  <= 1'b0;
            rq_s3_r  <= 1'b0;
            scl_s1_r <= 1'b1;
            scl_s2_r <= 1'b1;
            sda_s1_r <= 1'b1;
            sda_s2_r <= 1'b1;
            sda_d_r  <= 1'b1;
            lbusy_r  <= 1'b0;
        end else begin
            rq_s1_r  <= req_tgl_r;
            rq_s2_r  <= rq_s1_r;
            rq_s3_r  <= rq_s2_r;
            scl_s1_r <= scl_i;
            scl_s2_r <= scl_s1_r;
            sda_s1_r <= sda_i;
            sda_s2_r <= sda_s1_r;
            sda_d_r  <= sda_s2_r;
            if (start_det) begin
                lbusy_r <= 1'b1;
            end else if (stop_det) begin
                lbusy_r <= 1'b0;
            end
        end
    end

    // Quarter-bit timer; it freezes during a stretch.
    always_ff @(posedge link_clk or negedge resetn) begin
        if (!resetn) begin
            div_r <= 5'h0;
        end else if (!active || tick) begin
            div_r <= qtr - 5'h1;
        end else if (!stretch) begin
            div_r <= div_r - 5'h1;
        end
    end

    // [R1] Bit engine: only ever initiates transfers.
    always_ff @(posedge link_clk or negedge resetn) begin
        if (!resetn) begin
            st_r       <= i2cmc_pkg::S_IDLE;
            own_r      <= 1'b0;
            q_r        <= i2cmc_pkg::Q0;
            bit_r      <= 4'h0;
            sh_r       <= 8'h00;
            scl_oe_r   <= 1'b0;
            sda_oe_r   <= 1'b0;
            nack_r     <= 1'b0;
            lost_r     <= 1'b0;
            done_tgl_r <= 1'b0;
            rdata_r    <= 8'h00;
        end else if (lose) begin
            // [R8] Release both lines, abandon.
            scl_oe_r <= 1'b0;
            sda_oe_r <= 1'b0;
            own_r    <= 1'b0;
            lost_r   <= 1'b1;
            st_r     <= i2cmc_pkg::S_DONE;
        end else begin
            if (tick) begin
                q_r <= q_r + 2'h1;
            end
            case (st_r)
                i2cmc_pkg::S_IDLE: begin
                    if (req_ev) begin
                        lost_r <= 1'b0;
                        nack_r <= 1'b0;
                        sh_r   <= c_wdata_r;
                        st_r   <= i2cmc_pkg::S_WAIT;
                    end
                end
                i2cmc_pkg::S_WAIT: begin
                    q_r   <= i2cmc_pkg::Q0;
                    bit_r <= 4'h0;
                    // [R2] Start only on a free bus, or as a repeated start on a bus this master owns.
                    if (!need_start) begin
                        st_r <= i2cmc_pkg::S_BIT;
                    end else if (own_r || !lbusy_r) begin
                        st_r <= i2cmc_pkg::S_START;
                    end
                end
                i2cmc_pkg::S_START: begin
                    // [R7] Start or repeated start.
                    if (tick) begin
                        case (q_r)
                            i2cmc_pkg::Q0: sda_oe_r <= 1'b0;
                            i2cmc_pkg::Q1: scl_oe_r <= 1'b0;
                            i2cmc_pkg::Q2: sda_oe_r <= 1'b1;
                            default: begin
                                scl_oe_r <= 1'b1;
                                own_r    <= 1'b1;
                                st_r     <= i2cmc_pkg::S_BIT;
                            end
                        endcase
                    end
                end
                i2cmc_pkg::S_BIT: begin
                    // [R7] Eight data bits, then acknowledge.
                    if (tick) begin
                        case (q_r)
                            i2cmc_pkg::Q0: sda_oe_r <= drive_low;
                            i2cmc_pkg::Q1: scl_oe_r <= 1'b0;
                            i2cmc_pkg::Q2: begin
                                if (is_ack) begin
                                    nack_r <= sda_s2_r;
                                end else begin
                                    sh_r <= {sh_r[6:0], sda_s2_r};
                                end
                            end
                            default: begin
                                scl_oe_r <= 1'b1;
                                bit_r    <= bit_r + 4'h1;
                                if (is_ack) begin
                                    st_r <= c_stop_r ? i2cmc_pkg::S_STOP : i2cmc_pkg::S_DONE;
                                end
                            end
                        endcase
                    end
                end
                i2cmc_pkg::S_STOP: begin
                    // [R7] Stop: data rises while clock high.
                    if (tick) begin
                        case (q_r)
                            i2cmc_pkg::Q0: sda_oe_r <= 1'b1;
                            i2cmc_pkg::Q1: scl_oe_r <= 1'b0;
                            i2cmc_pkg::Q2: sda_oe_r <= 1'b0;
                            default: begin
                                own_r <= 1'b0;
                                st_r  <= i2cmc_pkg::S_DONE;
                            end
                        endcase
                    end
                end
                i2cmc_pkg::S_DONE: begin
                    rdata_r    <= sh_r;
                    done_tgl_r <= !done_tgl_r;
                    st_r       <= i2cmc_pkg::S_IDLE;
                end
                default: st_r <= i2cmc_pkg::S_IDLE;
            endcase
        end
    end
endmodule
`default_nettype wire

// *** testbench/i2cmc_checker.sv ***
// Port-level assertions for the two-wire bus master controller.
`timescale 1ns/1ps
`default_nettype none
module i2cmc_checker (
    input wire logic clk,       // Core clock.
    input wire logic resetn,    // Reset, active low.
    input wire logic link_clk,  // Bit engine clock.
    input wire logic cmd_valid, // Command offered.
    input wire logic cmd_ready, // Command can be taken.
    input wire logic rsp_valid, // Command finished.
    input wire logic rsp_lost,  // Answer says lost.
    input wire logic arb_lost,  // Sticky loss flag.
    input wire logic arb_clear, // Flag clear.
    input wire logic scl_i,     // Clock line level.
    input wire logic scl_o,     // Clock drive value.
    input wire logic scl_oe,    // Clock pulled low.
    input wire logic sda_o,     // Data drive value.
    input wire logic sda_oe     // Data pulled low.
);
    chk_drive_zero: assert property (@(posedge clk) disable iff (!resetn)
        !scl_o && !sda_o) else $error("line drive value not low");
    chk_ready_drop: assert property (@(posedge clk) disable iff (!resetn)
        cmd_valid && cmd_ready |=> !cmd_ready) else $error("ready stayed high after take");
    chk_rsp_pulse: assert property (@(posedge clk) disable iff (!resetn)
        rsp_valid |=> !rsp_valid) else $error("answer longer than one cycle");
    chk_ready_back: assert property (@(posedge clk) disable iff (!resetn)
        rsp_valid && !cmd_valid |=> cmd_ready) else $error("ready not back after answer");
    chk_lost_release: assert property (@(posedge clk) disable iff (!resetn)
        rsp_valid && rsp_lost |-> !scl_oe && !sda_oe) else $error("lines held after loss");
    chk_flag_set: assert property (@(posedge clk) disable iff (!resetn)
        rsp_valid && rsp_lost |-> ##[0:2] arb_lost) else $error("loss flag not set");
    chk_flag_hold: assert property (@(posedge clk) disable iff (!resetn)
        arb_lost && !arb_clear |=> arb_lost) else $error("loss flag dropped by itself");
    // no clocking while a target stretches
    chk_stretch_wait: assert property (@(posedge link_clk) disable iff (!resetn)
        !scl_oe && !scl_i && !$past(scl_i) && !$past(scl_i, 2) |=> !scl_oe)
        else $error("clock pulled during stretch");
endmodule
`default_nettype wire

// *** testbench/i2cmc_bus_model.sv ***
// Behavioural bus partner: pull-ups, one target and a second master.
`timescale 1ns/1ps
`default_nettype none
module i2cmc_bus_model (
    input  wire logic       scl_oe,     // Controller pulls clock low.
    input  wire logic       sda_oe,     // Controller pulls data low.
    input  wire logic       ack_en,     // Target acknowledges writes.
    input  wire logic       rd_mode,    // Target sends bytes.
    input  wire logic [7:0] rd_byte,    // Byte the target sends.
    input  wire logic       stretch_en, // Target stretches the clock.
    input  wire logic       other_low,  // Second master pulls data low.
    output wire logic       scl,        // Clock line level.
    output wire logic       sda         // Data line level.
);
    int   slot = 9;
    logic nk = 1'b0;
    logic hold = 1'b0;
    // target drives data bits or the acknowledge slot
    wire  tgt = rd_mode ? (slot < 8 && !rd_byte[7 - slot]) : (slot == 8 && ack_en);
    assign scl = !(scl_oe || hold);
    assign sda = !(sda_oe || tgt || other_low);
    // start or stop puts the target idle
    always @(sda) begin
        if (scl === 1'b1) begin
            slot = 9;
        end
    end
    // acknowledge level seen by the target
    always @(posedge scl) begin
        nk = sda;
    end
    // next bit slot; a refused read byte ends sending
    always @(negedge scl) begin
        slot = (slot == 8 && nk) ? 9 : (slot >= 8 ? 0 : slot + 1);
    end
    // target holds the clock low for a while
    always @(negedge scl) begin
        if (stretch_en) begin
            hold = 1'b1;
            #1500;
            hold = 1'b0;
        end
    end
endmodule
`default_nettype wire

// *** testbench/i2c_master_controller_tb_top.sv ***
// Self-checking bench for the two-wire bus master controller.
`timescale 1ns/1ps
`default_nettype none
module i2c_master_controller_tb_top;
    logic        clk = 1'b0, link_clk = 1'b0, resetn = 1'b0, cmd_valid = 1'b0;
    logic        cmd_start = 1'b0, cmd_stop = 1'b0, cmd_read = 1'b0, cmd_ack = 1'b0;
    logic [7:0]  cmd_wdata = 8'h00, rd_byte = 8'h00;
    logic [1:0]  cmd_rate = 2'h0;
    logic        supply_low = 1'b0, arb_clear = 1'b0;
    logic        ack_en = 1'b1, rd_mode = 1'b0, stretch_en = 1'b0, other_low = 1'b0;
    wire         cmd_ready, rsp_valid, rsp_nack, rsp_lost, arb_lost, bus_busy;
    wire         scl_oe, sda_oe, scl_w, sda_w, scl_o, sda_o;
    wire  [7:0]  rsp_rdata;
    logic [10:0] notes[$];
    logic [10:0] n;
    int          fails = 0, num_checks = 0, rsps = 0;
    realtime     t_prev = 0, per_min = 0;
    i2cmc_top dut_u (.clk(clk), .resetn(resetn), .link_clk(link_clk), .cmd_valid(cmd_valid),
        .cmd_ready(cmd_ready), .cmd_start(cmd_start), .cmd_stop(cmd_stop), .cmd_read(cmd_read),
        .cmd_ack(cmd_ack), .cmd_wdata(cmd_wdata), .cmd_rate(cmd_rate), .serial_bus_io_supply_low(supply_low),
        .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .rsp_nack(rsp_nack), .rsp_lost(rsp_lost),
        .arb_lost(arb_lost), .arb_clear(arb_clear), .bus_busy(bus_busy), .scl_i(scl_w), .scl_o(scl_o),
        .scl_oe(scl_oe), .sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe));
    i2cmc_bus_model bus_u (.scl_oe(scl_oe), .sda_oe(sda_oe), .ack_en(ack_en), .rd_mode(rd_mode),
        .rd_byte(rd_byte), .stretch_en(stretch_en), .other_low(other_low), .scl(scl_w), .sda(sda_w));
    // Core clock and a link clock of unrelated phase.
    initial begin
        forever #5 clk = ~clk;
    end
    initial begin
        #37;
        forever #80 link_clk = ~link_clk;
    end
    // Counts one comparison and reports a mismatch.
    task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // Note of a full answer: flag, byte, acknowledge level, no loss.
    function automatic logic [10:0] ok(input logic [7:0] d, input logic nk);
        return {1'b1, d, nk, 1'b0};
    endfunction
    // Offers one command, notes its answer and waits until taken.
    task automatic send(input logic [3:0] f, input logic [7:0] d, input logic [1:0] r, input logic [10:0] e);
        int i;
        notes.push_back(e);
        @(posedge clk);
        {cmd_start, cmd_stop, cmd_read, cmd_ack} <= f;
        cmd_wdata <= d;
        cmd_rate <= r;
        cmd_valid <= 1'b1;
        t_prev = 0;
        per_min = 1.0e9;
        for (i = 0; i < 100; i++) begin
            @(posedge clk);
            if (cmd_ready === 1'b1) break;
        end
        check("ready wait", 8'(cmd_ready === 1'b1), 8'h01);
        cmd_valid <= 1'b0;
    endtask
    // Waits for the answer of the command in flight.
    task automatic finish();
        int i;
        for (i = 0; i < 20000 && rsp_valid !== 1'b1; i++) @(posedge clk);
        check("answer wait", 8'(rsp_valid === 1'b1), 8'h01);
        @(posedge clk);
    endtask
    // Shortest clock period on the wire during the current command.
    always @(posedge scl_w) begin
        if (t_prev > 0 && $realtime - t_prev < per_min) per_min = $realtime - t_prev;
        t_prev = $realtime;
    end
    // Checks the shortest clock period against the quarter count and the nominal rate of a rate code.
    task automatic rate_ok(input int r);
        int  q;
        real p;
        q = (r == 1) ? i2cmc_pkg::QTR_FAST : (r == 2) ? i2cmc_pkg::QTR_FPLUS : i2cmc_pkg::QTR_STD;
        p = 1.0e9 / ((r == 1) ? i2cmc_pkg::FAST_HZ : (r == 2) ? i2cmc_pkg::FPLUS_HZ : i2cmc_pkg::STD_HZ);
        check("scl period", 8'(per_min >= 640.0 * q && per_min <= 160.0 * (4 * q + 4)), 8'h01);
        check("scl rate", 8'(per_min >= p), 8'h01);
    endtask
    // Takes the oldest note whenever an answer appears.
    always @(posedge clk) begin
        if (resetn === 1'b1 && rsp_valid === 1'b1) begin
            rsps++;
            check("note queue", 8'(notes.size() > 0), 8'h01);
            n = notes.pop_front();
            check("rsp_lost", {7'h00, rsp_lost}, {7'h00, n[0]});
            if (n[10]) begin
                check("rsp_nack", {7'h00, rsp_nack}, {7'h00, n[1]});
                check("rsp_rdata", rsp_rdata, n[9:2]);
            end
        end
    end
    // Prints the counts and the verdict, then ends the run.
    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // Cuts a hang short.
    initial begin
        #800_000;
        check("watchdog", 8'h00, 8'h01);
        close_out();
    end
    // Main sequence of scenarios.
    initial begin
        logic [7:0] d;
        int         r;
        void'($urandom(30645));
        repeat (2) @(posedge link_clk);
        @(posedge clk);
        resetn <= 1'b1;
        for (r = 0; r < 4; r++) begin
            d = 8'($urandom);
            send(4'hc, d, 2'(r), ok(d, 1'b0));
            finish();
            rate_ok(r);
        end
        // lowest supply level forces standard rate
        supply_low <= 1'b1;
        repeat (4) @(posedge link_clk);
        d = 8'($urandom);
        send(4'hc, d, i2cmc_pkg::RATE_FPLUS, ok(d, 1'b0));
        finish();
        rate_ok(i2cmc_pkg::RATE_STD);
        supply_low <= 1'b0;
        repeat (4) @(posedge link_clk);
        // missing acknowledge on a write; no stop, so the bus stays owned.
        ack_en = 1'b0;
        d = 8'($urandom);
        send(4'h8, d, i2cmc_pkg::RATE_FPLUS, ok(d, 1'b1));
        finish();
        ack_en = 1'b1;
        // repeated start while the bus is still owned.
        d = 8'($urandom);
        send(4'hc, d, i2cmc_pkg::RATE_FPLUS, ok(d, 1'b0));
        finish();
        // read acknowledged, then read refused with stop
        rd_mode = 1'b1;
        rd_byte = 8'($urandom);
        send(4'hb, 8'hff, i2cmc_pkg::RATE_FPLUS, ok(rd_byte, 1'b0));
        finish();
        rd_byte = 8'($urandom);
        send(4'h6, 8'hff, i2cmc_pkg::RATE_FPLUS, ok(rd_byte, 1'b1));
        finish();
        rd_mode = 1'b0;
        // target stretches every low clock phase
        stretch_en = 1'b1;
        d = 8'($urandom);
        send(4'hc, d, i2cmc_pkg::RATE_FPLUS, ok(d, 1'b0));
        finish();
        stretch_en = 1'b0;
        // a second master holds the bus; the command waits for its stop
        other_low = 1'b1;
        repeat (100) @(posedge clk);
        check("bus_busy", {7'h00, bus_busy}, 8'h01);
        r = rsps;
        d = 8'($urandom);
        send(4'hc, d, i2cmc_pkg::RATE_FPLUS, ok(d, 1'b0));
        repeat (2000) @(posedge clk);
        check("early answer", 8'(rsps - r), 8'h00);
        other_low = 1'b0;
        finish();
        // a second master wins the first data bit
        send(4'hc, 8'hff, i2cmc_pkg::RATE_FPLUS, 11'h001);
        @(posedge sda_oe);
        @(negedge scl_w);
        other_low = 1'b1;
        finish();
        other_low = 1'b0;
        repeat (10) @(posedge clk);
        check("arb_lost", {7'h00, arb_lost}, 8'h01);
        arb_clear <= 1'b1;
        @(posedge clk);
        arb_clear <= 1'b0;
        repeat (3) @(posedge clk);
        check("arb_lost", {7'h00, arb_lost}, 8'h00);
        close_out();
    end
endmodule
bind i2cmc_top i2cmc_checker chk_u (.clk(clk), .resetn(resetn), .link_clk(link_clk), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_lost(rsp_lost), .arb_lost(arb_lost),
    .arb_clear(arb_clear), .scl_i(scl_i), .scl_o(scl_o), .scl_oe(scl_oe), .sda_o(sda_o), .sda_oe(sda_oe));
`default_nettype wire
